// File: dsr_dev.sv
// converter end: conversion cycle, mode choice and serial result output
// assumes link pins resolved in dsr_link_if; cs and sck arrive unsynchronised
`timescale 1ns/1ps
`default_nettype none
module dsr_dev #(
   parameter int unsigned POR_CYC = dsr_pkg::POR_CYC,
   parameter int unsigned CONV_CYC = dsr_pkg::CONV_CYC,
   parameter int unsigned TEST_CYC = dsr_pkg::STATUS_TEST_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   dsr_link_if.dev link,
   input wire logic [dsr_pkg::RESULT_BITS-1:0] sample_i,
   output logic busy_o,
   output logic ext_mode_o,
   output logic reading_o
);
   dsr_pkg::dsr_dev_state_t state_r;
   logic cs_m_r;
   logic cs_s_r;
   logic cs_d_r;
   logic sck_m_r;
   logic sck_s_r;
   logic sck_d_r;
   logic [31:0] timer_r;
   logic [dsr_pkg::WORD_BITS-1:0] sreg_r;
   logic [5:0] cnt_r;
   logic [2:0] div_r;
   logic ext_mode_r;
   logic hold_hi_r;
   logic pu_r;
   logic [1:0] pu_wait_r;
   logic cs_fall;
   logic cs_rise;
   logic rise_ev;
   logic fall_ev;
   logic last_bit;
   logic gen_sck;

   // first stages only feed second stages
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cs_m_r <= 1'b1;
         cs_s_r <= 1'b1;
         cs_d_r <= 1'b1;
         sck_m_r <= 1'b1;
         sck_s_r <= 1'b1;
         sck_d_r <= 1'b1;
      end else begin
         cs_m_r <= link.cs_b;
         cs_s_r <= cs_m_r;
         cs_d_r <= cs_s_r;
         sck_m_r <= link.sck;
         sck_s_r <= sck_m_r;
         sck_d_r <= sck_s_r;
      end
   end

   assign cs_fall = cs_d_r & ~cs_s_r;
   assign cs_rise = ~cs_d_r & cs_s_r;
   assign gen_sck = div_r < 3'(dsr_pkg::SCK_HALF);
   // internal clock edges come from the divider, external ones from the pin
   assign rise_ev = ext_mode_r ? (sck_s_r & ~sck_d_r) : (div_r == 3'(dsr_pkg::SCK_DIV - 1));
   assign fall_ev = ext_mode_r ? (~sck_s_r & sck_d_r) : (div_r == 3'(dsr_pkg::SCK_HALF - 1));
   assign last_bit = cnt_r == 6'(dsr_pkg::WORD_BITS);

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r <= dsr_pkg::DEV_POR;
         timer_r <= 32'(POR_CYC - 1);
         cnt_r <= '0;
      end else begin
         unique case (state_r)
            dsr_pkg::DEV_POR: begin
               if (timer_r == '0) begin
                  state_r <= dsr_pkg::DEV_CONV;
                  timer_r <= 32'(CONV_CYC - 1);
               end else begin
                  timer_r <= timer_r - 1'b1;
               end
            end
            dsr_pkg::DEV_CONV: begin
               if (timer_r == '0) begin
                  state_r <= dsr_pkg::DEV_SLEEP;
               end else begin
                  timer_r <= timer_r - 1'b1;
               end
            end
            dsr_pkg::DEV_SLEEP: begin
               if (ext_mode_r && !cs_s_r && sck_s_r && !sck_d_r) begin
                  state_r <= dsr_pkg::DEV_OUT;
                  cnt_r <= 6'h01;
               end else if (!ext_mode_r && !cs_s_r) begin
                  state_r <= dsr_pkg::DEV_TEST;
                  timer_r <= 32'(TEST_CYC - 1);
               end
            end
            dsr_pkg::DEV_TEST: begin
               if (cs_s_r) begin
                  state_r <= dsr_pkg::DEV_SLEEP;
               end else if (timer_r == '0) begin
                  state_r <= dsr_pkg::DEV_OUT;
                  cnt_r <= 6'h01;
               end else begin
                  timer_r <= timer_r - 1'b1;
               end
            end
            dsr_pkg::DEV_OUT: begin
               if (cs_rise) begin
                  state_r <= dsr_pkg::DEV_CONV;
                  timer_r <= 32'(CONV_CYC - 1);
               end else if (fall_ev && last_bit) begin
                  state_r <= dsr_pkg::DEV_CONV;
                  timer_r <= 32'(CONV_CYC - 1);
               end else if (rise_ev) begin
                  cnt_r <= cnt_r + 6'h01;
               end
            end
            default: begin
               state_r <= dsr_pkg::DEV_POR;
               timer_r <= 32'(POR_CYC - 1);
            end
         endcase
      end
   end

   // divider restarts at readout entry so the first internal rise is immediate
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_r <= '0;
      end else if (state_r == dsr_pkg::DEV_OUT) begin
         div_r <= div_r + 3'h1;
      end else begin
         div_r <= '0;
      end
   end

   // result word: busy flag slot first, then the sample, msb first
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sreg_r <= '0;
      end else if (state_r == dsr_pkg::DEV_CONV && timer_r == '0) begin
         sreg_r <= {1'b0, sample_i};
      end else if (state_r == dsr_pkg::DEV_OUT && fall_ev && !last_bit && !cs_rise) begin
         sreg_r <= {sreg_r[dsr_pkg::WORD_BITS-2:0], 1'b0};
      end
   end

   // mode is sampled from the synchronised pin, never the raw one
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ext_mode_r <= 1'b0;
      end else if (state_r == dsr_pkg::DEV_POR && timer_r == '0) begin
         ext_mode_r <= ~sck_s_r;
      end else if (cs_fall && state_r != dsr_pkg::DEV_POR) begin
         ext_mode_r <= ~sck_s_r;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hold_hi_r <= 1'b0;
      end else if (!ext_mode_r && state_r == dsr_pkg::DEV_OUT && fall_ev && last_bit && !cs_rise) begin
         hold_hi_r <= 1'b1;
      end else if (cs_fall || (state_r == dsr_pkg::DEV_CONV && timer_r == '0)) begin
         hold_hi_r <= 1'b0;
      end
   end

   // weak pull-up cannot lift a line once low; a select rise outside readout revives it
   // synchroniser lags the pin, so its level is ignored until the revived line comes through
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pu_r <= 1'b1;
         pu_wait_r <= 2'h2;
      end else if (state_r == dsr_pkg::DEV_POR || (cs_rise && state_r != dsr_pkg::DEV_OUT)) begin
         pu_r <= 1'b1;
         pu_wait_r <= 2'h2;
      end else if (pu_wait_r != 2'h0) begin
         pu_wait_r <= pu_wait_r - 2'h1;
      end else begin
         pu_r <= sck_s_r;
      end
   end

   // abort during readout with the clock low leaves the line low, so the next select fall picks external mode
   assign link.dev_sck_oe = !ext_mode_r && state_r != dsr_pkg::DEV_POR && (!cs_s_r || hold_hi_r);
   assign link.dev_sck_o = (state_r == dsr_pkg::DEV_OUT) ? gen_sck : hold_hi_r;
   assign link.dev_sck_pu = pu_r;
   assign link.dev_sdo_oe = !cs_s_r && state_r != dsr_pkg::DEV_POR;
   assign link.dev_sdo_o = (state_r == dsr_pkg::DEV_CONV) | sreg_r[dsr_pkg::WORD_BITS-1];
   assign busy_o = state_r == dsr_pkg::DEV_CONV;
   assign ext_mode_o = ext_mode_r;
   assign reading_o = state_r == dsr_pkg::DEV_OUT;
endmodule // dsr_dev
`default_nettype wire

// File: dsr_fifo.sv
// synchronous fifo for received result words
// assumes single clock, producer respects in_ready
`timescale 1ns/1ps
`default_nettype none
module dsr_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 32
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_r;
   logic [AW:0] rd_r;
   logic push;
   logic pop;

   assign in_ready_o = (wr_r - rd_r) != (AW+1)'(DEPTH);
   assign out_valid_o = wr_r != rd_r;
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign out_data_o = mem[rd_r[AW-1:0]];

   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem[wr_r[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (push) begin
            wr_r <= wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= rd_r + 1'b1;
         end
      end
   end
endmodule // dsr_fifo
`default_nettype wire

// File: dsr_host.sv
// host end: selects the converter, reads 32-bit words into a fifo
// assumes the converter shares core_clk_i; link pins are synchronised anyway
`timescale 1ns/1ps
`default_nettype none
module dsr_host #(
   parameter int unsigned HALF = dsr_pkg::HOST_HALF,
   parameter int unsigned SETTLE = dsr_pkg::HOST_SETTLE,
   parameter int unsigned DEPTH = dsr_pkg::FIFO_DEPTH
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   dsr_link_if.host link,
   input wire logic start_i,
   input wire logic ext_mode_i,
   output logic word_valid_o,
   input wire logic word_ready_i,
   output logic [dsr_pkg::WORD_BITS-1:0] word_o,
   output logic busy_o
);
   dsr_pkg::dsr_host_state_t state_r;
   logic sdo_m_r;
   logic sdo_s_r;
   logic sck_m_r;
   logic sck_s_r;
   logic sck_d_r;
   logic ext_r;
   logic cs_b_r;
   logic sck_r;
   logic [7:0] tmr_r;
   logic [5:0] cnt_r;
   logic [dsr_pkg::WORD_BITS-1:0] word_r;
   logic fifo_ready;

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sdo_m_r <= 1'b0;
         sdo_s_r <= 1'b0;
         sck_m_r <= 1'b1;
         sck_s_r <= 1'b1;
         sck_d_r <= 1'b1;
      end else begin
         sdo_m_r <= link.serial_data_out;
         sdo_s_r <= sdo_m_r;
         sck_m_r <= link.sck;
         sck_s_r <= sck_m_r;
         sck_d_r <= sck_s_r;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r <= dsr_pkg::HST_IDLE;
         ext_r <= 1'b0;
         cs_b_r <= 1'b1;
         sck_r <= 1'b0;
         tmr_r <= '0;
         cnt_r <= '0;
         word_r <= '0;
      end else begin
         unique case (state_r)
            dsr_pkg::HST_IDLE: begin
               // no readout starts unless the fifo has room for its word
               if (start_i && fifo_ready) begin
                  ext_r <= ext_mode_i;
                  cs_b_r <= 1'b0;
                  sck_r <= 1'b0;
                  tmr_r <= 8'(SETTLE);
                  cnt_r <= '0;
                  state_r <= dsr_pkg::HST_SETTLE;
               end
            end
            dsr_pkg::HST_SETTLE: begin
               if (tmr_r == '0) begin
                  state_r <= ext_r ? dsr_pkg::HST_WAIT : dsr_pkg::HST_INT;
               end else begin
                  tmr_r <= tmr_r - 8'h01;
               end
            end
            dsr_pkg::HST_WAIT: begin
               if (!sdo_s_r) begin
                  tmr_r <= 8'(HALF - 1);
                  state_r <= dsr_pkg::HST_CLK;
               end
            end
            dsr_pkg::HST_CLK: begin
               if (tmr_r != '0) begin
                  tmr_r <= tmr_r - 8'h01;
               end else begin
                  tmr_r <= 8'(HALF - 1);
                  sck_r <= ~sck_r;
                  if (!sck_r) begin
                     word_r <= {word_r[dsr_pkg::WORD_BITS-2:0], sdo_s_r};
                     cnt_r <= cnt_r + 6'h01;
                  end else if (cnt_r == 6'(dsr_pkg::WORD_BITS)) begin
                     state_r <= dsr_pkg::HST_PUSH;
                  end
               end
            end
            dsr_pkg::HST_INT: begin
               if (sck_s_r && !sck_d_r) begin
                  word_r <= {word_r[dsr_pkg::WORD_BITS-2:0], sdo_s_r};
                  cnt_r <= cnt_r + 6'h01;
                  if (cnt_r == 6'(dsr_pkg::WORD_BITS - 1)) begin
                     state_r <= dsr_pkg::HST_PUSH;
                  end
               end
            end
            dsr_pkg::HST_PUSH: begin
               if (fifo_ready) begin
                  tmr_r <= 8'(2 * SETTLE);
                  state_r <= dsr_pkg::HST_GAP;
               end
            end
            // select stays low until the new busy flag has shown, then a gap
            dsr_pkg::HST_GAP: begin
               if (tmr_r == 8'(SETTLE)) begin
                  cs_b_r <= 1'b1;
               end
               if (tmr_r == '0) begin
                  state_r <= dsr_pkg::HST_IDLE;
               end else begin
                  tmr_r <= tmr_r - 8'h01;
               end
            end
            default: begin
               state_r <= dsr_pkg::HST_IDLE;
               cs_b_r <= 1'b1;
            end
         endcase
      end
   end

   dsr_fifo #(
      .WIDTH(dsr_pkg::WORD_BITS),
      .DEPTH(DEPTH)
   ) dsr_fifo_inst (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(state_r == dsr_pkg::HST_PUSH),
      .in_ready_o(fifo_ready),
      .in_data_i(word_r),
      .out_valid_o(word_valid_o),
      .out_ready_i(word_ready_i),
      .out_data_o(word_o)
   );

   // external mode keeps the clock driven low whenever idle
   assign link.cs_b = cs_b_r;
   assign link.host_sck_oe = ext_r;
   assign link.host_sck_o = sck_r;
   assign busy_o = state_r != dsr_pkg::HST_IDLE;
endmodule // dsr_host
`default_nettype wire

// File: dsr_link_if.sv
// three-wire link between converter and host, with pin resolution
// assumes an undriven clock line with pull-up off floats to low
`timescale 1ns/1ps
`default_nettype none
interface dsr_link_if;
   logic cs_b;
   logic host_sck_o;
   logic host_sck_oe;
   logic dev_sck_o;
   logic dev_sck_oe;
   logic dev_sck_pu;
   logic dev_sdo_o;
   logic dev_sdo_oe;
   logic sck;
   logic serial_data_out;

   assign sck = host_sck_oe ? host_sck_o : (dev_sck_oe ? dev_sck_o : dev_sck_pu);
   assign serial_data_out = dev_sdo_oe ? dev_sdo_o : 1'b0;

   modport dev (input cs_b, input sck, output dev_sck_o, output dev_sck_oe, output dev_sck_pu,
      output dev_sdo_o, output dev_sdo_oe);
   modport host (output cs_b, output host_sck_o, output host_sck_oe, input sck, input serial_data_out);
endinterface
`default_nettype wire

// File: dsr_pkg.sv
// constants and state codes shared by both ends of the converter readout link
// assumes one 50 MHz core clock on both ends
`default_nettype none
package dsr_pkg;
   localparam int unsigned CORE_CLK_HZ = 50_000_000;
   localparam int unsigned WORD_BITS = 32;
   localparam int unsigned RESULT_BITS = WORD_BITS - 1;
   localparam int unsigned SCK_DIV = 8;
   localparam int unsigned SCK_HALF = SCK_DIV / 2;
   localparam int unsigned STATUS_TEST_NS = 23_000;
   localparam int unsigned STATUS_TEST_CYC = (STATUS_TEST_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned POR_US = 500;
   localparam int unsigned POR_CYC = POR_US * (CORE_CLK_HZ / 1_000_000);
   localparam int unsigned CONV_MS = 133;
   localparam int unsigned CONV_CYC = CONV_MS * (CORE_CLK_HZ / 1000);
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned HOST_HALF = 8;
   localparam int unsigned HOST_SETTLE = 4;

   typedef enum logic [2:0] {
      DEV_POR = 3'h0,
      DEV_CONV = 3'h1,
      DEV_SLEEP = 3'h2,
      DEV_TEST = 3'h3,
      DEV_OUT = 3'h4
   } dsr_dev_state_t;

   typedef enum logic [2:0] {
      HST_IDLE = 3'h0,
      HST_SETTLE = 3'h1,
      HST_WAIT = 3'h2,
      HST_CLK = 3'h3,
      HST_INT = 3'h4,
      HST_PUSH = 3'h5,
      HST_GAP = 3'h6
   } dsr_host_state_t;
endpackage
`default_nettype wire

// File: dsr_sva.sv
// assertions on the link between converter and host
// assumes the link signals of one joined pair, one core clock
`timescale 1ns/1ps
`default_nettype none
module dsr_sva #(
   parameter int unsigned TEST_CYC = dsr_pkg::STATUS_TEST_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic cs_b,
   input wire logic host_sck_oe,
   input wire logic dev_sck_oe,
   input wire logic dev_sck_pu,
   input wire logic dev_sdo_oe,
   input wire logic sck,
   input wire logic serial_data_out
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   logic sck_r;
   logic [5:0] rises_r;
   logic [5:0] falls_r;
   logic [15:0] low_r;
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) sck_r <= 1'b1;
      else sck_r <= sck;
   end
   // counts restart at every deselect
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) rises_r <= 6'h00;
      else if (cs_b) rises_r <= 6'h00;
      else if (sck && !sck_r) rises_r <= rises_r + 6'h01;
   end
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) falls_r <= 6'h00;
      else if (cs_b) falls_r <= 6'h00;
      else if (host_sck_oe && !sck && sck_r && rises_r != 6'h00) falls_r <= falls_r + 6'h01;
   end
   // saturates so a long stall cannot wrap
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) low_r <= 16'h0000;
      else if (sck || !dev_sck_oe) low_r <= 16'h0000;
      else if (low_r != 16'hFFFF) low_r <= low_r + 16'h0001;
   end
   a_sdo_float_deselect: assert property (cs_b [*5] |-> !dev_sdo_oe)
      else $error("data output driven while deselected");
   a_flag_while_selected: assert property ((!cs_b) [*5] |-> dev_sdo_oe)
      else $error("data output not driven while selected");
   a_sdo_stable_rise: assert property ($rose(sck) |-> ($stable(serial_data_out)) [*4])
      else $error("data changed near a clock rise");
   a_ext_last_fall: assert property (host_sck_oe && !cs_b && falls_r == 6'd31 && $fell(sck)
      |-> ##[2:4] (serial_data_out && dev_sdo_oe))
      else $error("no busy flag after last external fall");
   a_int_high_half: assert property (dev_sck_oe && $rose(sck) |-> sck [*4])
      else $error("internal clock high phase wrong");
   a_int_low_half: assert property (dev_sck_oe && $fell(sck) && rises_r != 6'd0
      |-> (!sck) [*4] ##1 sck)
      else $error("internal clock low phase wrong");
   a_int_last_rise: assert property (dev_sck_oe && $rose(sck) && rises_r == 6'd31
      |-> ##[3:5] (sck && serial_data_out && dev_sdo_oe))
      else $error("no conversion after last internal rise");
   a_int_test_delay: assert property (dev_sck_oe && $rose(sck) && rises_r == 6'd0
      |-> low_r + 16'h0001 >= TEST_CYC)
      else $error("first internal rise too early");
   a_pull_low_off: assert property ((!sck && !cs_b) [*4] |-> !dev_sck_pu)
      else $error("pull-up on while clock low");
   a_pull_select_fall: assert property ($fell(cs_b) && !host_sck_oe
      |-> dev_sck_pu && sck ##[1:6] (dev_sck_oe && !sck))
      else $error("clock not pulled up then driven low");
endmodule // dsr_sva
`default_nettype wire

// File: test_adc_serial_readout_modes.sv
// bench for converter and host joined, plus a second converter driven here
// assumes short reset and conversion counts set below
`timescale 1ns/1ps
`default_nettype none
module test_adc_serial_readout_modes;
   localparam int unsigned POR = 20;
   localparam int unsigned CONV = 200;
   localparam int unsigned TEST = 10;
   localparam int unsigned HALF = dsr_pkg::HOST_HALF;
   localparam int LIMIT = 60000;
   logic core_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [dsr_pkg::RESULT_BITS-1:0] sample_i = 31'h0;
   logic start_i = 1'b0;
   logic ext_mode_i = 1'b0;
   logic word_ready_i = 1'b0;
   logic dev_busy, dev_ext, dev_reading, word_valid, host_busy, busy2, ext2, reading2;
   logic [dsr_pkg::WORD_BITS-1:0] word;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   dsr_link_if link ();
   dsr_link_if link2 ();
   dsr_dev #(.POR_CYC(POR), .CONV_CYC(CONV), .TEST_CYC(TEST)) dsr_dev_inst (.core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i), .link(link.dev), .sample_i(sample_i), .busy_o(dev_busy), .ext_mode_o(dev_ext),
      .reading_o(dev_reading));
   dsr_dev #(.POR_CYC(POR), .CONV_CYC(CONV), .TEST_CYC(TEST)) dsr_dev_inst2 (.core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i), .link(link2.dev), .sample_i(sample_i), .busy_o(busy2), .ext_mode_o(ext2),
      .reading_o(reading2));
   dsr_host dsr_host_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .link(link.host), .start_i(start_i),
      .ext_mode_i(ext_mode_i), .word_valid_o(word_valid), .word_ready_i(word_ready_i), .word_o(word),
      .busy_o(host_busy));
   dsr_sva #(.TEST_CYC(TEST)) dsr_sva_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .cs_b(link.cs_b),
      .host_sck_oe(link.host_sck_oe), .dev_sck_oe(link.dev_sck_oe), .dev_sck_pu(link.dev_sck_pu),
      .dev_sdo_oe(link.dev_sdo_oe), .sck(link.sck), .serial_data_out(link.serial_data_out));
   initial begin
      forever #10 core_clk_i = ~core_clk_i;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp_v);
      total_checks++;
      if (seen !== exp_v) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp_v);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // 0 dev busy, 1 host busy, 2 word valid, 3 second busy, 4 second reading
   function automatic logic pick(input int i);
      case (i)
         0: return dev_busy;
         1: return host_busy;
         2: return word_valid;
         3: return busy2;
         default: return reading2;
      endcase
   endfunction
   task automatic wait_for(input int i, input logic lvl, input int lim);
      int n;
      n = 0;
      @(negedge core_clk_i);
      while (pick(i) !== lvl && n < lim) begin
         @(negedge core_clk_i);
         n++;
      end
      check({31'h0, pick(i)}, {31'h0, lvl});
   endtask
   // sample set mid-conversion so the readout carries it
   task automatic read_one(input logic [30:0] val, input logic ext);
      wait_for(0, 1'b1, CONV + 2000);
      @(posedge core_clk_i);
      sample_i <= val;
      ext_mode_i <= ext;
      start_i <= 1'b1;
      wait_for(1, 1'b1, 50);
      @(posedge core_clk_i) start_i <= 1'b0;
      wait_for(1, 1'b0, 2 * CONV + 1200);
      check({31'h0, dev_ext}, {31'h0, ext});
      check({30'h0, dev_busy, dev_reading}, 32'h2);
   endtask
   task automatic pop_one(input logic [30:0] val);
      wait_for(2, 1'b1, 2000);
      check(word, {1'b0, val});
      @(posedge core_clk_i) word_ready_i <= 1'b1;
      @(posedge core_clk_i) word_ready_i <= 1'b0;
   endtask
   task automatic test_int_read();
      read_one(31'h1234_5678, 1'b0);
      pop_one(31'h1234_5678);
      $display("int_read done");
   endtask
   task automatic test_fifo_full();
      for (int k = 0; k < 32; k++) read_one(31'h0ABC_0000 | 31'(k), 1'b0);
      @(posedge core_clk_i) start_i <= 1'b1;
      repeat (40) @(negedge core_clk_i);
      check({31'h0, host_busy}, 32'h0);
      @(posedge core_clk_i) start_i <= 1'b0;
      for (int k = 0; k < 32; k++) pop_one(31'h0ABC_0000 | 31'(k));
      @(negedge core_clk_i) check({31'h0, word_valid}, 32'h0);
      $display("fifo_full done");
   endtask
   // internal mode leaves the clock high; external after it is safe
   task automatic test_ext_read();
      read_one(31'h2A5A_1234, 1'b1);
      pop_one(31'h2A5A_1234);
      $display("ext_read done");
   endtask
   task automatic test_pulse_abort();
      wait_for(3, 1'b0, CONV + 100);
      @(posedge core_clk_i) link2.cs_b <= 1'b0;
      repeat (TEST / 2) @(posedge core_clk_i);
      link2.cs_b <= 1'b1;
      repeat (30) @(negedge core_clk_i);
      check({31'h0, busy2}, 32'h0);
      check({31'h0, reading2}, 32'h0);
      check({31'h0, link2.dev_sck_pu}, 32'h1);
      check({31'h0, ext2}, 32'h0);
      @(posedge core_clk_i) link2.cs_b <= 1'b0;
      wait_for(4, 1'b1, TEST + 20);
      repeat (3 * dsr_pkg::SCK_DIV) @(posedge core_clk_i);
      link2.cs_b <= 1'b1;
      wait_for(3, 1'b1, 8);
      $display("pulse_abort done");
   endtask
   task automatic test_abort_ext();
      @(posedge core_clk_i) link2.host_sck_oe <= 1'b1;
      wait_for(3, 1'b0, CONV + 100);
      @(posedge core_clk_i) link2.cs_b <= 1'b0;
      repeat (6) @(negedge core_clk_i);
      check({30'h0, link2.dev_sdo_oe, link2.serial_data_out}, 32'h2);
      check({31'h0, ext2}, 32'h1);
      check({31'h0, reading2}, 32'h0);
      repeat (3) begin
         repeat (HALF) @(posedge core_clk_i);
         link2.host_sck_o <= 1'b1;
         repeat (HALF) @(posedge core_clk_i);
         link2.host_sck_o <= 1'b0;
      end
      @(negedge core_clk_i) check({31'h0, reading2}, 32'h1);
      @(posedge core_clk_i) link2.cs_b <= 1'b1;
      wait_for(3, 1'b1, 8);
      @(posedge core_clk_i) link2.cs_b <= 1'b0;
      repeat (6) @(negedge core_clk_i);
      check({30'h0, link2.dev_sdo_oe, link2.serial_data_out}, 32'h3);
      @(posedge core_clk_i) link2.cs_b <= 1'b1;
      repeat (6) @(negedge core_clk_i);
      check({31'h0, link2.dev_sdo_oe}, 32'h0);
      $display("abort_ext done");
   endtask
   // select tied low, clock held low through reset: two-wire external readout
   task automatic test_two_wire();
      logic [31:0] got;
      got = 32'h0;
      @(posedge core_clk_i);
      link2.host_sck_oe <= 1'b1;
      link2.host_sck_o <= 1'b0;
      link2.cs_b <= 1'b0;
      rst_b_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      wait_for(3, 1'b1, POR + 20);
      check({31'h0, ext2}, 32'h1);
      wait_for(3, 1'b0, CONV + 20);
      for (int k = 0; k < 32; k++) begin
         repeat (HALF) @(posedge core_clk_i);
         link2.host_sck_o <= 1'b1;
         @(negedge core_clk_i) got = {got[30:0], link2.serial_data_out};
         repeat (HALF) @(posedge core_clk_i);
         link2.host_sck_o <= 1'b0;
      end
      check(got, {1'b0, sample_i});
      wait_for(3, 1'b1, 8);
      $display("two_wire done");
   endtask
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         num_errors = num_errors + 1;
         end_of_test();
      end
   end
   initial begin
      link2.cs_b = 1'b1;
      link2.host_sck_o = 1'b0;
      link2.host_sck_oe = 1'b0;
      repeat (3) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      test_int_read();
      test_fifo_full();
      test_ext_read();
      test_pulse_abort();
      test_abort_ext();
      test_two_wire();
      end_of_test();
   end
endmodule // test_adc_serial_readout_modes
`default_nettype wire
